/* File: axis_status_outputs.sv */
// per-axis status flags for a two-axis servo amplifier and their pin mapping

// Functional notes
// [RULE1] zero-speed on at or below threshold
// [RULE2] threshold comes from a setting input
// [RULE3] stays on until threshold plus 20 r/min
// [RULE4] same levels in both rotation directions
// [RULE5] warning flag follows active warning
// [RULE6] warning flag settled off within 1.5 s
// [RULE7] battery flag on codes 92.1 or 9F.1
// [RULE8] battery flag settled off within 1.5 s
// [RULE9] variable-gain flag mirrors variable gain state
// [RULE10] abs-lost flag when position is lost
// [RULE11] no abs-lost flag in speed/torque modes
// [RULE12] flags reach pins only when assigned
// [RULE13] separate flag logic per axis
module axis_status_outputs #(
  parameter int SPEED_W = axis_status_pkg::SPEED_W,
  parameter int SETTLE_CYCLES = axis_status_pkg::SETTLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire axis_status_pkg::axis_in_t axisAIn,
  input wire axis_status_pkg::axis_in_t axisBIn,
  input wire logic [SPEED_W-1:0] zero_speed_threshold_param,
  input wire axis_status_pkg::out_assign_t output_assign_param_1,
  input wire axis_status_pkg::out_assign_t output_assign_param_2,
  output logic axis_a_zero_speed_flag,
  output logic axis_b_zero_speed_flag,
  output logic axis_a_warning_flag,
  output logic axis_b_warning_flag,
  output logic axis_a_battery_warning_flag,
  output logic axis_b_battery_warning_flag,
  output logic axis_a_variable_gain_active,
  output logic axis_b_variable_gain_active,
  output logic axis_a_abs_position_lost,
  output logic axis_b_abs_position_lost,
  output logic settled,
  output logic [axis_status_pkg::PIN_CNT-1:0] outPin
);

  // refuse a speed width other than the carrier width, and a settle count below one
  if (SPEED_W != axis_status_pkg::SPEED_W) begin : g_bad_speed_w
    $error("SPEED_W must equal the carrier speed width");
  end
  if (SETTLE_CYCLES < 1) begin : g_bad_settle
    $error("SETTLE_CYCLES must be positive");
  end

  localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);

  logic [CNT_W-1:0] settleCnt_r;
  logic settled_r;
  logic zeroSpeedA;
  logic zeroSpeedB;
  logic [SPEED_W-1:0] threshold;
  axis_status_pkg::axis_flags_t flagsA_r;
  axis_status_pkg::axis_flags_t flagsB_r;
  axis_status_pkg::axis_flags_t flagsA_nxt;
  axis_status_pkg::axis_flags_t flagsB_nxt;

  // a zero setting falls back to the default level
  assign threshold = (zero_speed_threshold_param == '0) ?
    SPEED_W'(axis_status_pkg::ZERO_SPEED_DEFAULT) : zero_speed_threshold_param; // RULE2

  // power-on settle timer; warning flags held off until it expires
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      settleCnt_r <= '0;
      settled_r <= 1'b0;
    end else if (!settled_r) begin
      if (settleCnt_r == CNT_W'(SETTLE_CYCLES - 1)) begin
        settled_r <= 1'b1; // RULE6 RULE8
      end
      settleCnt_r <= settleCnt_r + 1'b1;
    end
  end

  // one comparator per axis, each on its own speed
  zero_speed_detect #(.SPEED_W(SPEED_W)) u_zeroA (
    .sys_clk(sys_clk),
    .rst(rst),
    .speed(axisAIn.speed),
    .threshold(threshold),
    .zeroSpeed_r(zeroSpeedA)
  ); // RULE13
  zero_speed_detect #(.SPEED_W(SPEED_W)) u_zeroB (
    .sys_clk(sys_clk),
    .rst(rst),
    .speed(axisBIn.speed),
    .threshold(threshold),
    .zeroSpeed_r(zeroSpeedB)
  ); // RULE13

  function automatic axis_status_pkg::axis_flags_t evalFlags(
    input axis_status_pkg::axis_in_t ai,
    input logic zeroIn,
    input logic ready
  );
    axis_status_pkg::axis_flags_t f;
    logic batt;
    batt = (ai.warnCode == axis_status_pkg::WARN_BATT_CABLE) ||
      (ai.warnCode == axis_status_pkg::WARN_BATT_LOW); // RULE7
    f.zeroSpeed = zeroIn; // RULE1
    f.warning = ready && ai.warnActive; // RULE5
    f.battery = ready && ai.warnActive && batt; // RULE7
    f.varGain = ai.varGain; // RULE9
    f.absLost = ai.absLost && (ai.mode == axis_status_pkg::MODE_POSITION); // RULE10 RULE11
    return f;
  endfunction : evalFlags

  // per-axis flag evaluation from that axis's inputs only
  always_comb begin
    flagsA_nxt = evalFlags(axisAIn, zeroSpeedA, settled_r); // RULE13
    flagsB_nxt = evalFlags(axisBIn, zeroSpeedB, settled_r); // RULE13
  end

  // registered flag state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flagsA_r <= '0;
      flagsB_r <= '0;
    end else begin
      flagsA_r <= flagsA_nxt;
      flagsB_r <= flagsB_nxt;
    end
  end

  assign axis_a_zero_speed_flag = flagsA_r.zeroSpeed;
  assign axis_b_zero_speed_flag = flagsB_r.zeroSpeed;
  assign axis_a_warning_flag = flagsA_r.warning;
  assign axis_b_warning_flag = flagsB_r.warning;
  assign axis_a_battery_warning_flag = flagsA_r.battery;
  assign axis_b_battery_warning_flag = flagsB_r.battery;
  assign axis_a_variable_gain_active = flagsA_r.varGain;
  assign axis_b_variable_gain_active = flagsB_r.varGain;
  assign axis_a_abs_position_lost = flagsA_r.absLost;
  assign axis_b_abs_position_lost = flagsB_r.absLost;
  assign settled = settled_r;

  // output assignment settings route flags to the pins
  output_pin_map u_pin0 (
    .sys_clk(sys_clk),
    .rst(rst),
    .assign_cfg(output_assign_param_1),
    .flagsA(flagsA_r),
    .flagsB(flagsB_r),
    .pinDrive_r(outPin[0])
  ); // RULE12
  output_pin_map u_pin1 (
    .sys_clk(sys_clk),
    .rst(rst),
    .assign_cfg(output_assign_param_2),
    .flagsA(flagsA_r),
    .flagsB(flagsB_r),
    .pinDrive_r(outPin[1])
  ); // RULE12

  a_warn_follow: assert property (@(posedge sys_clk) disable iff (rst)
    (settled_r && axisAIn.warnActive) |=> axis_a_warning_flag)
    else $error("warning flag not set"); // RULE5
  a_warn_quiet_settle: assert property (@(posedge sys_clk) disable iff (rst)
    !settled_r |=> !axis_a_warning_flag && !axis_b_warning_flag)
    else $error("warning flag before settle"); // RULE6
  a_settle_bound: assert property (@(posedge sys_clk) disable iff (rst)
    settled_r |-> settleCnt_r == CNT_W'(SETTLE_CYCLES))
    else $error("settle time wrong"); // RULE8
  a_batt_codes: assert property (@(posedge sys_clk) disable iff (rst)
    (settled_r && axisBIn.warnActive && axisBIn.warnCode == axis_status_pkg::WARN_BATT_LOW)
    |=> axis_b_battery_warning_flag) else $error("battery flag missed"); // RULE7
  a_varg_mirror: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 axis_a_variable_gain_active == $past(axisAIn.varGain))
    else $error("variable gain mismatch"); // RULE9
  a_abs_mode_block: assert property (@(posedge sys_clk) disable iff (rst)
    (axisAIn.mode != axis_status_pkg::MODE_POSITION) |=> !axis_a_abs_position_lost)
    else $error("abs flag in speed or torque mode"); // RULE11
  a_abs_set: assert property (@(posedge sys_clk) disable iff (rst)
    (axisBIn.absLost && axisBIn.mode == axis_status_pkg::MODE_POSITION)
    |=> axis_b_abs_position_lost) else $error("abs flag missed"); // RULE10
  a_pin_route_a: assert property (@(posedge sys_clk) disable iff (rst)
    (output_assign_param_1.sel == axis_status_pkg::SEL_WARNING &&
     !output_assign_param_1.axisB) |=> outPin[0] == $past(axis_a_warning_flag))
    else $error("pin route wrong"); // RULE12

  // further guards, most axis checks mirrored on the other axis so a cross-wired axis is caught; warning clear and other-code battery checks cover axis A only
  a_batt_quiet_settle: assert property (@(posedge sys_clk) disable iff (rst)
    !settled_r |=> !axis_a_battery_warning_flag && !axis_b_battery_warning_flag)
    else $error("battery flag before settle"); // RULE8
  a_settle_early: assert property (@(posedge sys_clk) disable iff (rst)
    !settled_r |-> settleCnt_r < CNT_W'(SETTLE_CYCLES))
    else $error("settle counter overran"); // RULE6
  a_warn_follow_b: assert property (@(posedge sys_clk) disable iff (rst)
    (settled_r && axisBIn.warnActive) |=> axis_b_warning_flag)
    else $error("warning flag B not set"); // RULE5
  a_warn_clear: assert property (@(posedge sys_clk) disable iff (rst)
    !axisAIn.warnActive |=> !axis_a_warning_flag)
    else $error("warning flag without warning"); // RULE5
  a_batt_code_a: assert property (@(posedge sys_clk) disable iff (rst)
    (settled_r && axisAIn.warnActive && axisAIn.warnCode == axis_status_pkg::WARN_BATT_CABLE)
    |=> axis_a_battery_warning_flag) else $error("cable battery flag missed"); // RULE7
  a_batt_other_code: assert property (@(posedge sys_clk) disable iff (rst)
    (axisAIn.warnCode != axis_status_pkg::WARN_BATT_CABLE &&
     axisAIn.warnCode != axis_status_pkg::WARN_BATT_LOW) |=> !axis_a_battery_warning_flag)
    else $error("battery flag on other code"); // RULE7
  a_varg_mirror_b: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 axis_b_variable_gain_active == $past(axisBIn.varGain))
    else $error("variable gain B mismatch"); // RULE9
  a_abs_set_a: assert property (@(posedge sys_clk) disable iff (rst)
    (axisAIn.absLost && axisAIn.mode == axis_status_pkg::MODE_POSITION)
    |=> axis_a_abs_position_lost) else $error("abs flag A missed"); // RULE10
  a_abs_mode_b: assert property (@(posedge sys_clk) disable iff (rst)
    (axisBIn.mode != axis_status_pkg::MODE_POSITION) |=> !axis_b_abs_position_lost)
    else $error("abs flag B in speed or torque mode"); // RULE11
  a_zero_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 axis_a_zero_speed_flag == $past(zeroSpeedA))
    else $error("zero speed flag A mismatch"); // RULE1
  a_zero_flag_b: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 axis_b_zero_speed_flag == $past(zeroSpeedB))
    else $error("zero speed flag B mismatch"); // RULE13
  a_pin_route_b: assert property (@(posedge sys_clk) disable iff (rst)
    (output_assign_param_2.sel == axis_status_pkg::SEL_BATTERY &&
     output_assign_param_2.axisB) |=> outPin[1] == $past(axis_b_battery_warning_flag))
    else $error("pin 2 route wrong"); // RULE12

endmodule : axis_status_outputs

/* File: axis_status_pkg.sv */
// shared constants and carriers for the per-axis status flag outputs
package axis_status_pkg;

  localparam int SPEED_W = 16;
  localparam int FLAG_CNT = 5;
  localparam int SEL_W = 3;
  localparam int PIN_CNT = 2;

  // zero-speed levels in r/min
  localparam logic [SPEED_W-1:0] ZERO_SPEED_DEFAULT = 16'h0032;
  localparam logic [SPEED_W-1:0] ZERO_SPEED_HYST = 16'h0014;

  // power-on settle time
  localparam real SETTLE_TIME_S = 1.5;
  localparam real CLK_PERIOD_NS = 4.0;
  localparam int SETTLE_CYCLES = int'(SETTLE_TIME_S * 1.0e9 / CLK_PERIOD_NS);

  // warning codes, tens, ones and tenths digits, one hex nibble each
  localparam logic [11:0] WARN_BATT_CABLE = 12'h921;
  localparam logic [11:0] WARN_BATT_LOW = 12'h9F1;
  localparam logic [11:0] WARN_NONE = 12'h000;

  // flag selector codes used by the output assignment parameters
  localparam logic [SEL_W-1:0] SEL_NONE = 3'h0;
  localparam logic [SEL_W-1:0] SEL_ZERO_SPEED = 3'h1;
  localparam logic [SEL_W-1:0] SEL_WARNING = 3'h2;
  localparam logic [SEL_W-1:0] SEL_BATTERY = 3'h3;
  localparam logic [SEL_W-1:0] SEL_VAR_GAIN = 3'h4;
  localparam logic [SEL_W-1:0] SEL_ABS_LOST = 3'h5;

  // axis selector bit within an assignment code
  localparam int AXIS_BIT = SEL_W;

  typedef enum logic [2:0] {
    MODE_POSITION = 3'h1,
    MODE_SPEED = 3'h2,
    MODE_TORQUE = 3'h4
  } ctrl_mode_t;

  typedef struct packed {
    logic signed [SPEED_W-1:0] speed;
    logic [11:0] warnCode;
    logic warnActive;
    logic varGain;
    logic absLost;
    ctrl_mode_t mode;
  } axis_in_t;

  typedef struct packed {
    logic zeroSpeed;
    logic warning;
    logic battery;
    logic varGain;
    logic absLost;
  } axis_flags_t;

  typedef struct packed {
    logic axisB;
    logic [SEL_W-1:0] sel;
  } out_assign_t;

endpackage : axis_status_pkg

/* File: output_pin_map.sv */
// maps one selected axis flag onto one output pin
module output_pin_map (
  input wire logic sys_clk,
  input wire logic rst,
  input wire axis_status_pkg::out_assign_t assign_cfg,
  input wire axis_status_pkg::axis_flags_t flagsA,
  input wire axis_status_pkg::axis_flags_t flagsB,
  output logic pinDrive_r
);

  axis_status_pkg::axis_flags_t f;
  logic pinDrive_nxt;

  // pick the axis, then the flag; unassigned stays off
  always_comb begin
    f = assign_cfg.axisB ? flagsB : flagsA;
    pinDrive_nxt = 1'b0;
    unique case (assign_cfg.sel)
      axis_status_pkg::SEL_ZERO_SPEED: pinDrive_nxt = f.zeroSpeed;
      axis_status_pkg::SEL_WARNING: pinDrive_nxt = f.warning;
      axis_status_pkg::SEL_BATTERY: pinDrive_nxt = f.battery;
      axis_status_pkg::SEL_VAR_GAIN: pinDrive_nxt = f.varGain;
      axis_status_pkg::SEL_ABS_LOST: pinDrive_nxt = f.absLost;
      default: pinDrive_nxt = 1'b0; // RULE12
    endcase
  end

  // registered pin drive
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinDrive_r <= 1'b0;
    end else begin
      pinDrive_r <= pinDrive_nxt; // RULE12
    end
  end

  a_pin_unassigned: assert property (@(posedge sys_clk) disable iff (rst)
    (assign_cfg.sel == axis_status_pkg::SEL_NONE) |=> !pinDrive_r)
    else $error("unassigned pin driven"); // RULE12

endmodule : output_pin_map

/* File: seq_controller_model.sv */
// external sequence controller model that latches the amplifier output pins
module seq_controller_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] pinIn,
  output logic [1:0] pinSeen_r
);
  timeunit 1ns;
  timeprecision 1ps;
  // input stage of the controller samples the pins once per clock
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinSeen_r <= 2'h0;
    end else begin
      pinSeen_r <= pinIn;
    end
  end
endmodule : seq_controller_model

/* File: tb_top.sv */
// self-checking bench for the two-axis status flag block
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin miscompares++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SETTLE = 20;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  axis_status_pkg::axis_in_t axA, axB;
  logic [15:0] thr = 16'h0000;
  axis_status_pkg::out_assign_t as1 = 4'h0, as2 = 4'h0;
  logic zA, zB, wA, wB, bA, bB, gA, gB, lA, lB, settled;
  logic [1:0] outPin, pinSeen;
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;

  axis_status_outputs #(.SETTLE_CYCLES(SETTLE)) axis_status_outputs_inst (
    .sys_clk(sys_clk), .rst(rst), .axisAIn(axA), .axisBIn(axB),
    .zero_speed_threshold_param(thr),
    .output_assign_param_1(as1), .output_assign_param_2(as2),
    .axis_a_zero_speed_flag(zA), .axis_b_zero_speed_flag(zB),
    .axis_a_warning_flag(wA), .axis_b_warning_flag(wB),
    .axis_a_battery_warning_flag(bA), .axis_b_battery_warning_flag(bB),
    .axis_a_variable_gain_active(gA), .axis_b_variable_gain_active(gB),
    .axis_a_abs_position_lost(lA), .axis_b_abs_position_lost(lB),
    .settled(settled), .outPin(outPin));

  seq_controller_model seq_controller_model_inst (
    .sys_clk(sys_clk), .rst(rst), .pinIn(outPin), .pinSeen_r(pinSeen));

  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;

  // cycle ceiling against hangs
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic close_out();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out

  // let a flag input change reach flags, pins and the controller; a speed change reaches only flags and pins
  task automatic wt();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : wt

  task automatic spd(input logic [15:0] s, input logic e);
    @(posedge sys_clk);
    axA.speed <= s;
    wt();
    `CHK(zA, e, "zero speed flag A")
    `CHK(zB, 1'b0, "zero speed flag B disturbed")
  endtask : spd

  task automatic test_settle();
    wt();
    `CHK(wA, 1'b0, "warning before settle")
    `CHK(bA, 1'b0, "battery before settle")
    repeat (SETTLE + 2) @(posedge sys_clk);
    #1;
    `CHK(settled, 1'b1, "settled missing")
    `CHK(wA, 1'b1, "warning after settle")
    `CHK(bA, 1'b1, "battery after settle")
    `CHK(wB, 1'b0, "warning B idle")
    `CHK(bB, 1'b0, "battery B idle")
    $display("test settle done");
  endtask : test_settle

  task automatic test_zero();
    spd(16'h0064, 1'b0);
    spd(16'h0033, 1'b0);
    spd(16'h0032, 1'b1);
    spd(16'h0045, 1'b1);
    spd(16'h0046, 1'b0);
    spd(16'h0032, 1'b1);
    spd(16'hFFBB, 1'b1);
    spd(16'hFFBA, 1'b0);
    spd(16'hFFCE, 1'b1);
    @(posedge sys_clk);
    thr <= 16'h001E;
    spd(16'h0064, 1'b0);
    spd(16'h001F, 1'b0);
    spd(16'h001E, 1'b1);
    spd(16'h0031, 1'b1);
    spd(16'h0032, 1'b0);
    $display("test zero speed done");
  endtask : test_zero

  task automatic test_warn();
    logic [11:0] codes [3] = '{12'h921, 12'h9F1, 12'h123};
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      axA.warnCode <= codes[i];
      axA.warnActive <= 1'b1;
      wt();
      `CHK(wA, 1'b1, "warning flag")
      `CHK(bA, (i < 2), "battery flag by code")
    end
    @(posedge sys_clk);
    axA.warnActive <= 1'b0;
    wt();
    `CHK(wA, 1'b0, "warning clear")
    `CHK(bA, 1'b0, "battery clear")
    $display("test warning done");
  endtask : test_warn

  task automatic test_mode();
    axis_status_pkg::ctrl_mode_t m [3] = '{axis_status_pkg::MODE_SPEED,
      axis_status_pkg::MODE_TORQUE, axis_status_pkg::MODE_POSITION};
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      axA.absLost <= 1'b1;
      axA.varGain <= (i != 1);
      axA.mode <= m[i];
      axB.varGain <= (i == 1);
      wt();
      `CHK(gB, (i == 1), "variable gain B mirror")
      `CHK(lA, (i == 2), "abs lost by mode")
      `CHK(gA, (i != 1), "variable gain mirror")
      `CHK(lB, 1'b0, "abs lost B disturbed")
    end
    $display("test mode done");
  endtask : test_mode

  task automatic test_pins();
    @(posedge sys_clk);
    axA.speed <= 16'h03E8;
    axB.speed <= 16'h0000;
    axB.warnActive <= 1'b1;
    axB.warnCode <= 12'h9F1;
    for (int s = 0; s < 8; s++) begin
      @(posedge sys_clk);
      as1 <= {1'b0, 3'(s)};
      as2 <= {1'b1, 3'(s)};
      wt();
      `CHK(pinSeen[0], (s == 4 || s == 5), "pin 1 axis A")
      `CHK(pinSeen[1], (s >= 1 && s <= 3), "pin 2 axis B")
    end
    $display("test pins done");
  endtask : test_pins

  initial begin
    axA = '{16'h0064, 12'h921, 1'b1, 1'b0, 1'b0, axis_status_pkg::MODE_POSITION};
    axB = '{16'h03E8, 12'h000, 1'b0, 1'b0, 1'b0, axis_status_pkg::MODE_POSITION};
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    test_settle();
    test_warn();
    test_zero();
    test_mode();
    test_pins();
    close_out();
  end
endmodule : tb_top

/* File: zero_speed_detect.sv */
// zero-speed comparator with hysteresis for one axis
module zero_speed_detect #(
  parameter int SPEED_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic signed [SPEED_W-1:0] speed,
  input wire logic [SPEED_W-1:0] threshold,
  output logic zeroSpeed_r
);

  logic [SPEED_W-1:0] speedMag;
  logic [SPEED_W:0] offLevel;

  // magnitude makes both directions behave alike
  assign speedMag = speed[SPEED_W-1] ? SPEED_W'(-speed) : SPEED_W'(speed); // RULE4
  assign offLevel = {1'b0, threshold} + {1'b0, SPEED_W'(axis_status_pkg::ZERO_SPEED_HYST)}; // RULE3

  // set at or below the on level, clear only at the off level
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      zeroSpeed_r <= 1'b0;
    end else if (!zeroSpeed_r && speedMag <= threshold) begin
      zeroSpeed_r <= 1'b1; // RULE1
    end else if (zeroSpeed_r && {1'b0, speedMag} >= offLevel) begin
      zeroSpeed_r <= 1'b0; // RULE3
    end
  end

  // guards on the on level, the hysteresis band and the off level
  a_zero_on_level: assert property (@(posedge sys_clk) disable iff (rst)
    (speedMag <= threshold) |=> zeroSpeed_r) else $error("zero speed not set"); // RULE1
  a_zero_hold_band: assert property (@(posedge sys_clk) disable iff (rst)
    (zeroSpeed_r && {1'b0, speedMag} < offLevel) |=> zeroSpeed_r)
    else $error("zero speed dropped inside band"); // RULE3
  a_zero_off_level: assert property (@(posedge sys_clk) disable iff (rst)
    ({1'b0, speedMag} >= offLevel) |=> !zeroSpeed_r) else $error("zero speed not cleared"); // RULE4

endmodule : zero_speed_detect
